// ### src/usx_map.vh
// Notes on behaviour
// - tx done when shifter and buffer empty
// - interrupt acknowledge clears tx done flag
// - writing one clears tx done flag
// - request interrupt when enabled flag sets
// - parity bit after last data bit
// - tx disable waits for frames to drain
// - disabled transmitter releases the data pin
// - rx enable takes over receive pin
// - synchronous mode samples on transfer clock
// - reception starts on valid start bit
// - sample bits through first stop bit
// - second stop bit is ignored
// - first stop moves frame into buffer
// - unused high data bits read zero
// - rx complete set while unread data
// - rx disable flushes the receive buffer
// - two-entry buffer, read advances position
`ifndef USX_MAP_VH
`define USX_MAP_VH
// register addresses
`define USX_ADDR_DATA 3'h0
`define USX_ADDR_STAT 3'h1
`define USX_ADDR_CTRL 3'h2
`define USX_ADDR_FMT 3'h3
`define USX_ADDR_BAUD_LO 3'h4
`define USX_ADDR_BAUD_HI 3'h5
// status_reg_a fields
`define USX_STAT_RX_DONE 7
`define USX_STAT_TX_DONE 6
`define USX_STAT_TX_EMPTY 5
// control fields
`define USX_CTRL_TX_IRQ_EN 6
`define USX_CTRL_RX_EN 4
`define USX_CTRL_TX_EN 3
// format fields
`define USX_FMT_SYNC 6
`define USX_FMT_PAR_HI 5
`define USX_FMT_PAR_ODD 4
`define USX_FMT_STOP2 3
`define USX_FMT_SIZE_HI 2
`define USX_FMT_SIZE_LO 1
// reset values
`define USX_CTRL_RST 8'h00
`define USX_FMT_RST 8'h06
`define USX_BAUD_RST 12'h000
// timing and transmit buffer depth
`define USX_OS_LAST 4'hf
`define USX_OS_MID 4'h7
`define USX_TX_FIFO_DEPTH 4
`endif

// ### src/usx_core.v
`timescale 1ns/1ps
`include "usx_map.vh"

// small synchronous fifo, used as the transmit buffer
module usx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset, pointers do
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers wrap at depth
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// serial transceiver: tx complete, parity, tx drain, receive path
module usx_core (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // register port
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  // serial pins
  input wire RXD_PIN,
  input wire XCK_PIN,
  output reg TXD_OUT,
  output reg TXD_OE,
  output reg RXD_OWNED,
  // interrupt handshake with the cpu
  input wire GLOBAL_IRQ_EN,
  input wire IRQ_ACK,
  output reg TX_DONE_IRQ,
  // transmit buffer fill ready
  output reg TX_BUF_READY
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_STOP2 = 3'h5;

  // software registers
  reg [7:0] ctrl_q;
  reg [7:0] fmt_q;
  reg [11:0] baud_q;
  reg tx_done_q;
  wire tx_done_irq_en = ctrl_q[`USX_CTRL_TX_IRQ_EN];
  wire rx_enable_bit = ctrl_q[`USX_CTRL_RX_EN];
  wire tx_enable_bit = ctrl_q[`USX_CTRL_TX_EN];
  wire sync_mode = fmt_q[`USX_FMT_SYNC];
  wire parity_mode_hi = fmt_q[`USX_FMT_PAR_HI];
  wire [1:0] char_size = fmt_q[`USX_FMT_SIZE_HI:`USX_FMT_SIZE_LO];
  wire [2:0] last_bit = {1'b1, char_size};
  wire data_wr = WR && (ADDR == `USX_ADDR_DATA);
  wire data_rd = RD && (ADDR == `USX_ADDR_DATA);
  wire [7:0] size_mask = 8'hff >> (2'h3 - char_size);

  // pin input filters: three stages, accept when last two agree
  reg [2:0] rxd_s_q;
  reg [2:0] xck_s_q;
  reg rxd_f_q;
  reg xck_f_q;
  reg xck_prev_q;
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rxd_s_q <= 3'h7;
      xck_s_q <= 3'h0;
      rxd_f_q <= 1'b1;
      xck_f_q <= 1'b0;
      xck_prev_q <= 1'b0;
    end else begin
      rxd_s_q <= {rxd_s_q[1:0], RXD_PIN};
      xck_s_q <= {xck_s_q[1:0], XCK_PIN};
      if (rxd_s_q[1] == rxd_s_q[2]) begin
        rxd_f_q <= rxd_s_q[2];
      end
      if (xck_s_q[1] == xck_s_q[2]) begin
        xck_f_q <= xck_s_q[2];
      end
      xck_prev_q <= xck_f_q;
    end
  end
  wire xck_rise = xck_f_q && !xck_prev_q;
  wire xck_fall = !xck_f_q && xck_prev_q;

  // oversample tick, sixteen per bit in asynchronous mode
  reg [11:0] pre_q;
  reg os_tick_q;
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pre_q <= 12'h000;
      os_tick_q <= 1'b0;
    end else begin
      os_tick_q <= (pre_q == 12'h000);
      pre_q <= (pre_q == 12'h000) ? baud_q : pre_q - 12'h001;
    end
  end

  // transmit buffer
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg fifo_pop;
  usx_fifo #(
    .WIDTH(8),
    .DEPTH(`USX_TX_FIFO_DEPTH),
    .AW(2)
  ) u_tx_buf (
    .clk(REF_CLK),
    .resetn(RESETN),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(WDATA),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // transmitter: bit boundary from the tick or the falling clock edge
  reg [2:0] tx_st_q;
  reg [3:0] tx_os_q;
  reg [2:0] tx_idx_q;
  reg [7:0] tx_sh_q;
  reg tx_par_q;
  reg tx_active_q;
  reg tx_frame_end;
  wire tx_bit = sync_mode ? xck_fall : (os_tick_q && tx_os_q == `USX_OS_LAST);
  always @* begin
    fifo_pop = tx_active_q && tx_st_q == ST_IDLE && fifo_out_valid;
    tx_frame_end = tx_bit && ((tx_st_q == ST_STOP && !fmt_q[`USX_FMT_STOP2])
      || tx_st_q == ST_STOP2);
  end
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_st_q <= ST_IDLE;
      tx_os_q <= 4'h0;
      tx_idx_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_active_q <= 1'b0;
      TXD_OUT <= 1'b1;
      TXD_OE <= 1'b0;
    end else begin
      if (os_tick_q) begin
        tx_os_q <= tx_os_q + 4'h1;
      end
      // disable only once shifter and buffer are empty
      if (tx_enable_bit) begin
        tx_active_q <= 1'b1;
      end else if (tx_st_q == ST_IDLE && !fifo_out_valid) begin
        tx_active_q <= 1'b0;
      end
      TXD_OE <= tx_active_q;
      case (tx_st_q)
        ST_IDLE: begin
          TXD_OUT <= 1'b1;
          if (fifo_pop) begin
            tx_sh_q <= fifo_out_data & size_mask;
            tx_par_q <= (^(fifo_out_data & size_mask)) ^ fmt_q[`USX_FMT_PAR_ODD];
            tx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tx_bit) begin
            TXD_OUT <= 1'b0;
            tx_idx_q <= 3'h0;
            tx_st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_bit) begin
            TXD_OUT <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q == last_bit) begin
              tx_st_q <= parity_mode_hi ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (tx_bit) begin
            TXD_OUT <= tx_par_q;
            tx_st_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_bit) begin
            TXD_OUT <= 1'b1;
            tx_st_q <= fmt_q[`USX_FMT_STOP2] ? ST_STOP2 : ST_IDLE;
          end
        end
        ST_STOP2: begin
          if (tx_bit) begin
            TXD_OUT <= 1'b1;
            tx_st_q <= ST_IDLE;
          end
        end
        default: begin
          tx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // tx done flag: the set wins over both clears
  wire tx_done_set = tx_frame_end && !fifo_out_valid;
  wire tx_done_clr = IRQ_ACK
    || (WR && ADDR == `USX_ADDR_STAT && WDATA[`USX_STAT_TX_DONE]);
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_done_q <= 1'b0;
      TX_DONE_IRQ <= 1'b0;
      TX_BUF_READY <= 1'b0;
    end else begin
      if (tx_done_set) begin
        tx_done_q <= 1'b1;
      end else if (tx_done_clr) begin
        tx_done_q <= 1'b0;
      end
      TX_DONE_IRQ <= tx_done_irq_en && GLOBAL_IRQ_EN
        && (tx_done_set || (tx_done_q && !tx_done_clr));
      TX_BUF_READY <= fifo_in_ready;
    end
  end

  // receiver; software sets format before enabling
  reg [2:0] rx_st_q;
  reg [3:0] rx_os_q;
  reg [2:0] rx_idx_q;
  reg [7:0] rx_sh_q;
  reg [7:0] rx_buf_q [0:1];
  reg rx_wp_q;
  reg rx_rp_q;
  reg [1:0] rx_cnt_q;
  reg rx_push;
  wire rx_bit = sync_mode ? xck_rise : (os_tick_q && rx_os_q == `USX_OS_LAST);
  wire rx_pop = data_rd && rx_cnt_q != 2'h0;
  always @* begin
    rx_push = rx_st_q == ST_STOP && rx_bit && rx_cnt_q != 2'h2;
  end
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_st_q <= ST_IDLE;
      rx_os_q <= 4'h0;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      RXD_OWNED <= 1'b0;
    end else begin
      RXD_OWNED <= rx_enable_bit;
      if (os_tick_q) begin
        rx_os_q <= rx_os_q + 4'h1;
      end
      if (!rx_enable_bit) begin
        rx_st_q <= ST_IDLE;
      end else begin
        case (rx_st_q)
          ST_IDLE: begin
            // wait for the line to fall
            if (sync_mode && xck_rise && !rxd_f_q) begin
              rx_idx_q <= 3'h0;
              rx_st_q <= ST_DATA;
            end else if (!sync_mode && os_tick_q && !rxd_f_q) begin
              rx_os_q <= 4'h0;
              rx_st_q <= ST_START;
            end
          end
          ST_START: begin
            // a glitch shorter than half a bit is no start bit
            if (os_tick_q && rx_os_q == `USX_OS_MID) begin
              rx_os_q <= 4'h0;
              rx_idx_q <= 3'h0;
              rx_st_q <= rxd_f_q ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_bit) begin
              rx_sh_q <= {rxd_f_q, rx_sh_q[7:1]};
              rx_idx_q <= rx_idx_q + 3'h1;
              if (rx_idx_q == last_bit) begin
                rx_st_q <= parity_mode_hi ? ST_PAR : ST_STOP;
              end
            end
          end
          ST_PAR: begin
            if (rx_bit) begin
              rx_st_q <= ST_STOP;
            end
          end
          ST_STOP: begin
            // back to idle at once, any second stop just looks idle
            if (rx_bit) begin
              rx_st_q <= ST_IDLE;
            end
          end
          default: begin
            rx_st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // right-align the shifted frame and clear unused bits
  wire [7:0] rx_frame = (rx_sh_q >> (2'h3 - char_size)) & size_mask;

  // two-entry receive buffer, a full buffer drops the new frame
  always @(posedge REF_CLK) begin
    if (rx_push) begin
      rx_buf_q[rx_wp_q] <= rx_frame;
    end
  end
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_wp_q <= 1'b0;
      rx_rp_q <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else if (!rx_enable_bit) begin
      rx_wp_q <= 1'b0;
      rx_rp_q <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= ~rx_wp_q;
      end
      if (rx_pop) begin
        rx_rp_q <= ~rx_rp_q;
      end
      if (rx_push && !rx_pop) begin
        rx_cnt_q <= rx_cnt_q + 2'h1;
      end else if (rx_pop && !rx_push) begin
        rx_cnt_q <= rx_cnt_q - 2'h1;
      end
    end
  end

  // register writes
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= `USX_CTRL_RST;
      fmt_q <= `USX_FMT_RST;
      baud_q <= `USX_BAUD_RST;
    end else if (WR) begin
      case (ADDR)
        `USX_ADDR_CTRL: ctrl_q <= WDATA;
        `USX_ADDR_FMT: fmt_q <= WDATA;
        `USX_ADDR_BAUD_LO: baud_q <= {baud_q[11:8], WDATA};
        `USX_ADDR_BAUD_HI: baud_q <= {WDATA[3:0], baud_q[7:0]};
        default: baud_q <= baud_q;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `USX_ADDR_DATA: RDATA <= (rx_cnt_q != 2'h0) ? rx_buf_q[rx_rp_q] : 8'h00;
        `USX_ADDR_STAT: RDATA <= {rx_cnt_q != 2'h0, tx_done_q, !fifo_out_valid, 5'h00};
        `USX_ADDR_CTRL: RDATA <= ctrl_q;
        `USX_ADDR_FMT: RDATA <= fmt_q;
        `USX_ADDR_BAUD_LO: RDATA <= baud_q[7:0];
        `USX_ADDR_BAUD_HI: RDATA <= {4'h0, baud_q[11:8]};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule

// ### bench/usx_core_chk.sv
`timescale 1ns/1ps
`include "usx_map.vh"
// watches the transceiver at its top ports
module usx_core_chk (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // register port
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  // pins and interrupt
  input wire TXD_OUT,
  input wire TXD_OE,
  input wire RXD_OWNED,
  input wire GLOBAL_IRQ_EN,
  input wire IRQ_ACK,
  input wire TX_DONE_IRQ
);
  reg [1:0] size_q;
  wire [7:0] keep = 8'hff >> (2'd3 - size_q);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // shadow of the frame size, so the read mask is known
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) size_q <= 2'h3;
    else if (WR && ADDR == `USX_ADDR_FMT) size_q <= WDATA[2:1];
  end
  property p_rd_idle;
    !$past(RD) |-> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
  property p_mask;
    $past(RD) && $past(ADDR) == `USX_ADDR_DATA |-> (RDATA & ~keep) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("unused data bits set");
  property p_flush;
    $past(RD) && $past(ADDR) == `USX_ADDR_STAT && !$past(RXD_OWNED)
      |-> !RDATA[`USX_STAT_RX_DONE];
  endproperty
  a_flush: assert property (p_flush) else $error("rx flag with rx off");
  property p_own;
    WR && ADDR == `USX_ADDR_CTRL |-> ##2 RXD_OWNED == $past(WDATA[`USX_CTRL_RX_EN], 2);
  endproperty
  a_own: assert property (p_own) else $error("pin ownership wrong");
  property p_gie;
    TX_DONE_IRQ |-> $past(GLOBAL_IRQ_EN);
  endproperty
  a_gie: assert property (p_gie) else $error("irq while masked");
  property p_done;
    $rose(TX_DONE_IRQ) |-> TXD_OUT && $past(TXD_OUT) && $past(TXD_OUT, 2);
  endproperty
  a_done: assert property (p_done) else $error("tx done mid frame");
  property p_ack;
    IRQ_ACK |-> ##2 !TX_DONE_IRQ;
  endproperty
  a_ack: assert property (p_ack) else $error("ack left irq up");
  property p_own_tx;
    !TXD_OUT |-> TXD_OE;
  endproperty
  a_own_tx: assert property (p_own_tx) else $error("low bit on released pin");
  property p_drain;
    $fell(TXD_OE) |-> TXD_OUT && $past(TXD_OUT);
  endproperty
  a_drain: assert property (p_drain) else $error("pin released mid frame");
  property p_w1c;
    WR && ADDR == `USX_ADDR_STAT && WDATA[6] ##[1:2] RD && ADDR == `USX_ADDR_STAT
      |=> !RDATA[`USX_STAT_TX_DONE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("tx done not cleared");
endmodule

// ### bench/usx_peer.sv
`timescale 1ns/1ps
// far end of the serial line, async framing at 16 clocks a bit, or a
// synchronous frame on a transfer clock that this end supplies
module usx_peer (
  // clock
  input wire clk,
  // transfer clock for synchronous mode, low outside frames
  output reg xck_out,
  // line from the block, already resolved with its pull-up
  input wire line_in,
  // line into the block, idle high
  output reg line_out
);
  int n_bits = 8;
  bit par_on = 1'b0;
  bit par_odd = 1'b0;
  logic [31:0] rx_q[$];
  initial begin
    line_out = 1'b1;
    xck_out = 1'b0;
  end
  // one frame lsb first, parity or a high bit if off, then two stops so the second is exercised
  task automatic send(input int d);
    int i;
    bit p;
    p = ^(d & ((1 << n_bits) - 1)) ^ par_odd;
    for (i = -1; i < n_bits + 3; i++) begin
      @(posedge clk);
      line_out <= i < 0 ? 1'b0 : i < n_bits ? d[i] : i > n_bits || !par_on || p;
      repeat (15) @(posedge clk);
    end
  endtask
  // a start edge too short to be a frame
  task automatic glitch;
    @(posedge clk);
    line_out <= 1'b0;
    repeat (5) @(posedge clk);
    line_out <= 1'b1;
    repeat (200) @(posedge clk);
  endtask
  // synchronous frame: data set while the clock is low, sampled on its rise
  task automatic ssend(input int d);
    int i;
    for (i = -1; i <= n_bits; i++) begin
      @(posedge clk);
      line_out <= i < 0 ? 1'b0 : i < n_bits ? d[i] : 1'b1;
      repeat (7) @(posedge clk);
      xck_out <= 1'b1;
      repeat (8) @(posedge clk);
      xck_out <= 1'b0;
    end
  endtask
  // decode the block's frames at mid bit, parity kept in bit n_bits
  initial begin
    int i;
    logic [31:0] v;
    forever begin
      @(negedge line_in);
      repeat (8) @(posedge clk);
      v = 0;
      for (i = 0; i <= n_bits; i++) begin
        repeat (16) @(posedge clk);
        v[i] = line_in;
      end
      rx_q.push_back(v);
    end
  end
endmodule

// ### bench/test_usx_core.sv
`timescale 1ns/1ps
`include "usx_map.vh"
// one counted compare, reported at once on a difference
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH %0t value differs", $time); end end
module test_usx_core;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg gie = 1'b0;
  reg ack = 1'b0;
  reg [7:0] r;
  wire rxd, txd, oe, owned, irq, bready, line, ext_transfer_clock_pin;
  wire [7:0] rdata;
  int n_errors = 0;
  int n_checks = 0;
  int exp_q[$];
  // line seen by the peer, pulled up while the pin is released
  assign line = oe ? txd : 1'b1;
  usx_core usx_core_i (
    .REF_CLK(clk), .RESETN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RXD_PIN(rxd), .XCK_PIN(ext_transfer_clock_pin), .TXD_OUT(txd), .TXD_OE(oe),
    .RXD_OWNED(owned), .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack), .TX_DONE_IRQ(irq),
    .TX_BUF_READY(bready)
  );
  usx_peer usx_peer_i (.clk(clk), .xck_out(ext_transfer_clock_pin), .line_in(line), .line_out(rxd));
  initial forever #5 clk = ~clk;
  // bus cycles, one strobe cycle each
  task wr_reg(input [2:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task chk_rd(input [2:0] a, input int e, input int m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
    `CHK(r & m, e)
  endtask
  // what the peer decoded against the model, oldest first
  task chk_tx;
    logic [31:0] g;
    int e;
    while (exp_q.size() > 0) begin
      g = usx_peer_i.rx_q.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard; the tests need far less than this
  initial begin
    #200us;
    n_errors++;
    end_sim;
  end
  initial begin
    int i;
    int d;
    d = $urandom(32'he7cfa546);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // reset values and an unmapped place
    chk_rd(`USX_ADDR_CTRL, 8'h00, 8'hff);
    chk_rd(`USX_ADDR_FMT, 8'h06, 8'hff);
    chk_rd(3'h7, 8'h00, 8'hff);
    chk_rd(`USX_ADDR_STAT, 8'h20, 8'he0);
    $display("reset test done");
    wr_reg(`USX_ADDR_CTRL, 8'h10);
    @(posedge clk);
    #1 `CHK(owned, 1'b1)
    // every size, three frames each, the third meets a full buffer
    for (i = 0; i < 4; i++) begin
      wr_reg(`USX_ADDR_FMT, {5'h0, i[1:0], 1'b0} | (i[0] ? 8'h28 : 8'h00));
      usx_peer_i.n_bits = i + 5;
      usx_peer_i.par_on = i[0];
      repeat (3) begin
        d = $urandom & 8'hff;
        if (exp_q.size() < 2) exp_q.push_back(d & (8'hff >> (3 - i)));
        usx_peer_i.send(d);
      end
      chk_rd(`USX_ADDR_STAT, 8'h80, 8'h80);
      repeat (2) chk_rd(`USX_ADDR_DATA, exp_q.pop_front(), 8'hff);
      chk_rd(`USX_ADDR_STAT, 8'h00, 8'h80);
    end
    // disable flushes, a short start pulse is no frame
    usx_peer_i.send(8'h5a);
    chk_rd(`USX_ADDR_STAT, 8'h80, 8'h80);
    wr_reg(`USX_ADDR_CTRL, 8'h00);
    chk_rd(`USX_ADDR_STAT, 8'h00, 8'h80);
    wr_reg(`USX_ADDR_CTRL, 8'h10);
    usx_peer_i.glitch;
    chk_rd(`USX_ADDR_STAT, 8'h00, 8'h80);
    // synchronous mode, the peer supplies the transfer clock
    wr_reg(`USX_ADDR_FMT, 8'h46);
    usx_peer_i.n_bits = 8;
    usx_peer_i.par_on = 1'b0;
    d = $urandom & 8'hff;
    usx_peer_i.ssend(d);
    chk_rd(`USX_ADDR_DATA, d, 8'hff);
    $display("receive test done");
    // five words with odd parity, enough to fill the transmit buffer
    gie <= 1'b1;
    wr_reg(`USX_ADDR_FMT, 8'h36);
    usx_peer_i.n_bits = 8;
    usx_peer_i.par_on = 1'b1;
    usx_peer_i.par_odd = 1'b1;
    wr_reg(`USX_ADDR_CTRL, 8'h58);
    for (i = 0; i < 5; i++) begin
      d = $urandom & 8'hff;
      exp_q.push_back(d | ((^d[7:0] ^ 1) << 8));
      wr_reg(`USX_ADDR_DATA, d[7:0]);
      if (i == 0) repeat (20) @(posedge clk);
    end
    @(posedge clk);
    #1 `CHK(bready, 1'b0)
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    chk_tx;
    // taking the interrupt clears the flag
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    chk_rd(`USX_ADDR_STAT, 8'h00, 8'h40);
    `CHK(irq, 1'b0)
    // disable right behind a write: the frame still leaves, then the pin is freed
    // even parity and two stops this time, so done comes as the second stop starts
    wr_reg(`USX_ADDR_FMT, 8'h2e);
    d = $urandom & 8'hff;
    exp_q.push_back(d | ((^d[7:0]) ? 32'h100 : 32'h0));
    wr_reg(`USX_ADDR_DATA, d[7:0]);
    wr_reg(`USX_ADDR_CTRL, 8'h50);
    #1 `CHK(oe, 1'b1)
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    for (i = 0; i < 50 && oe !== 1'b0; i++) @(posedge clk);
    #1 `CHK(oe, 1'b0)
    chk_tx;
    // writing zero keeps the flag, writing one clears it
    wr_reg(`USX_ADDR_STAT, 8'h00);
    chk_rd(`USX_ADDR_STAT, 8'h40, 8'h40);
    wr_reg(`USX_ADDR_STAT, 8'h40);
    chk_rd(`USX_ADDR_STAT, 8'h00, 8'h40);
    $display("transmit test done");
    end_sim;
  end
endmodule
bind usx_core usx_core_chk usx_core_chk_i (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TXD_OUT(TXD_OUT), .TXD_OE(TXD_OE), .RXD_OWNED(RXD_OWNED),
  .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ_ACK(IRQ_ACK), .TX_DONE_IRQ(TX_DONE_IRQ)
);
